/* core/fad_pkg.sv */
/*
  constants, field layouts, register offsets and enumerations for the
  alarm delay and latching core.
  assumes a 50 mhz system clock and a word-aligned register port.
*/

package fad_pkg;

  // ---------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;              // 50 mhz system clock
  localparam int SEC_NS = 1_000_000_000;          // one second in ns
  localparam int TICK_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS; // cycles per tick

  // ---------------------------------------------------------------
  // times in seconds
  // ---------------------------------------------------------------
  localparam int SEC_W = 8;                       // width of second counters
  localparam logic [7:0] SEC_ONE = 8'h01;         // one second step
  localparam logic [7:0] RETARD_S = 8'h14;        // retard-reset phase, 20 s
  localparam logic [7:0] RESTART_DET_S = 8'h03;   // detector restart, 3 s
  localparam logic [7:0] RESTART_CZM_S = 8'h0A;   // zone module restart, 10 s
  localparam logic [7:0] SPAN_MAX_S = 8'h1E;      // retard to restart ceiling, 30 s
  localparam logic [7:0] ACK_S = 8'h0F;           // operator acknowledge window, 15 s
  localparam logic [7:0] VERIF_MIN_S = 8'h3C;     // verification 60 s
  localparam logic [7:0] VERIF_MAX_S = 8'hB4;     // verification 180 s
  localparam logic [7:0] VERIF_DEF_S = 8'h3C;     // verification default 60 s
  localparam logic [7:0] WF_MIN_S = 8'h0A;        // waterflow 10 s
  localparam logic [7:0] WF_MAX_S = 8'h5A;        // waterflow 90 s
  localparam logic [7:0] WF_DEF_S = 8'h5A;        // waterflow default 90 s
  localparam logic [7:0] DLY_MIN_S = 8'h3C;       // pre-signal / investigation 60 s
  localparam logic [7:0] DLY_MAX_S = 8'hB4;       // pre-signal / investigation 180 s
  localparam logic [7:0] DLY_DEF_S = 8'hB4;       // pre-signal / investigation 180 s

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;     // modes and command pulses
  localparam logic [11:0] VERIF_T_OFS = 12'h004;  // verification period
  localparam logic [11:0] WF_T_OFS = 12'h008;     // waterflow delay
  localparam logic [11:0] PS_T_OFS = 12'h00C;     // pre-signal delay
  localparam logic [11:0] PAS_T_OFS = 12'h010;    // investigation time
  localparam logic [11:0] STATUS_OFS = 12'h014;   // machine states and flags
  localparam logic [11:0] ACTIVE_OFS = 12'h018;   // held point states
  localparam logic [11:0] ALARMED_OFS = 12'h01C;  // registered fire alarms
  localparam logic [11:0] PCFG_BASE = 12'h100;    // per point config, one word each

  // control bits
  localparam int CTRL_DAY_LSB = 0;                // 2-bit day mode
  localparam int CTRL_PAS_EN = 2;                 // global sequence enable
  localparam int CTRL_SUP_LATCH = 3;              // supervisory points latch
  localparam int CTRL_ACK = 4;                    // write 1: acknowledge
  localparam int CTRL_RESET = 5;                  // write 1: panel reset

  // point config fields
  localparam int CFG_W = 8;
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_TYPE_W = 4;
  localparam int CFG_FEAT_LSB = 4;                // 2-bit delay feature
  localparam int CFG_WF_EN = 6;                   // waterflow delay enable
  localparam int CFG_CZM = 7;                     // conventional zone module

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PT_FIRE_AUTO = 4'h0, PT_FIRE_MANUAL = 4'h1, PT_WATERFLOW = 4'h2,
    PT_WF_DELAY = 4'h3, PT_GAS = 4'h4, PT_SUPERVISORY = 4'h5, PT_GENERIC = 4'h6,
    PT_TROUBLE = 4'h7, PT_AC_FAIL = 4'h8, PT_BATT_FAIL = 4'h9, PT_RESET = 4'hA,
    PT_SILENCE = 4'hB, PT_DRILL = 4'hC, PT_ACK = 4'hD, PT_GENERAL = 4'hE
  } point_type_e;

  typedef enum logic [1:0] {
    FEAT_NONE = 2'h0, FEAT_AV = 2'h1, FEAT_DAY = 2'h2, FEAT_DAY_AV = 2'h3
  } feature_e;

  typedef enum logic [1:0] {
    DAY_NONE = 2'h0, DAY_PAS = 2'h1, DAY_PS = 2'h2
  } day_e;

  typedef enum logic [1:0] {
    EFF_NONE = 2'h0, EFF_AV = 2'h1, EFF_PAS = 2'h2, EFF_PS = 2'h3
  } eff_e;

  typedef enum logic [1:0] {
    V_IDLE = 2'h0, V_RETARD = 2'h1, V_RESTART = 2'h2, V_CONFIRM = 2'h3
  } verif_e;

  typedef enum logic [1:0] {
    D_IDLE = 2'h0, D_ACK = 2'h1, D_WAIT = 2'h2, D_RELEASED = 2'h3
  } delay_e;

endpackage : fad_pkg

/* core/alarm_delay_core.sv */
/*
  alarm verification, waterflow delay, latching, pre-signal and positive
  alarm sequence processing for the input points of a fire panel.
  assumes point inputs arrive asynchronously from loop interfaces and that
  software drives the register port from the same clock.
*/

`timescale 1ns/1ps
`default_nettype none

module alarm_delay_core
  import fad_pkg::*;
#(
  parameter int NUM_POINTS = 16,                  // up to 32 points
  parameter int TICK_CYCLES = fad_pkg::TICK_CYCLES_DEF
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [fad_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [NUM_POINTS-1:0] point_in,     // loop point activation
  output logic [31:0] rdata,
  output logic alarm_out,                         // fire alarm indication
  output logic [NUM_POINTS-1:0] out_act,          // outputs mapped to each point
  output logic verif_zone,                        // global verification zone
  output logic presig_zone,                       // global pre-signal zone
  output logic evac_out,                          // evacuation and off-premises
  output logic loop_reset,                        // reset command pulse
  output logic [$clog2(NUM_POINTS)-1:0] loop_reset_pt
);

  import fad_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam int PT_W = $clog2(NUM_POINTS);
  localparam int CNT_W = $clog2(TICK_CYCLES);

  typedef struct packed {
    logic [CNT_W-1:0] div;                        // tick divider
    logic tick;                                   // one second pulse
    logic [NUM_POINTS-1:0] sync1;                 // first sync stage
    logic [NUM_POINTS-1:0] sync2;                 // second sync stage
    logic [1:0] day_mode;                         // day_e code
    logic pas_en;                                 // global sequence enable
    logic sup_latch;                              // supervisory latching
    logic [SEC_W-1:0] verif_t;
    logic [SEC_W-1:0] wf_t;
    logic [SEC_W-1:0] ps_t;
    logic [SEC_W-1:0] pas_t;
    logic [NUM_POINTS-1:0][CFG_W-1:0] cfg;        // per point config
    logic [NUM_POINTS-1:0][SEC_W-1:0] wf_cnt;     // per point waterflow seconds
    logic [NUM_POINTS-1:0] latched;               // held point state
    logic [NUM_POINTS-1:0] alarmed;               // fire alarm registered
    verif_e vst;
    logic [PT_W-1:0] vpt;                         // point under verification
    logic [SEC_W-1:0] vsec;                       // seconds since first alarm
    delay_e dst;
    logic [SEC_W-1:0] dsec;                       // seconds in delay phase
    logic alarm;
    logic [NUM_POINTS-1:0] out_act;
    logic verif_zone;
    logic presig_zone;
    logic evac;
    logic loop_reset;
    logic [PT_W-1:0] loop_reset_pt;
    logic [31:0] rdata;
  } state_s;

  state_s r;                                      // registered state
  state_s n;                                      // next state

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // fire alarm types, which all latch as well
  function automatic logic fire_like(input point_type_e t);
    fire_like = (t == PT_FIRE_AUTO) || (t == PT_FIRE_MANUAL) || (t == PT_WATERFLOW) ||
      (t == PT_WF_DELAY) || (t == PT_GENERAL);
  endfunction : fire_like

  // clamp a written time into its legal window
  function automatic logic [SEC_W-1:0] clamp(input logic [SEC_W-1:0] v,
    input logic [SEC_W-1:0] lo, input logic [SEC_W-1:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // delay actually applied to a point, by config and day mode
  function automatic eff_e eff_of(input logic [CFG_W-1:0] c, input logic [1:0] day,
    input logic pas_en);
    eff_e day_eff;
    day_eff = (day == DAY_PS) ? EFF_PS :
      ((day == DAY_PAS) && pas_en) ? EFF_PAS : EFF_NONE;
    eff_of = EFF_NONE;
    if (point_type_e'(c[CFG_TYPE_LSB +: CFG_TYPE_W]) == PT_FIRE_AUTO)
    begin
      unique case (feature_e'(c[CFG_FEAT_LSB +: 2]))
        FEAT_NONE: eff_of = EFF_NONE;
        FEAT_AV: eff_of = EFF_AV;
        FEAT_DAY: eff_of = day_eff;
        FEAT_DAY_AV: eff_of = (day == DAY_NONE) ? EFF_AV : day_eff;
      endcase
    end
  endfunction : eff_of

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    point_type_e typ;
    eff_e eff;
    logic [NUM_POINTS-1:0] held;
    logic [SEC_W-1:0] rs;
    logic [SEC_W-1:0] lim;
    logic [ADDR_W-1:0] idx;
    logic pan_rst, ack_wr, v_c_end, second, pas_kind, found, qual, lat, av_set;
    typ = PT_GENERIC;
    eff = EFF_NONE;
    held = '0;
    rs = r.cfg[r.vpt][CFG_CZM] ? RESTART_CZM_S : RESTART_DET_S;
    lim = (r.day_mode == DAY_PS) ? r.ps_t : r.pas_t;
    idx = (addr - PCFG_BASE) >> 2;
    pan_rst = wr_stb && (addr == CTRL_OFS) && wdata[CTRL_RESET];
    ack_wr = wr_stb && (addr == CTRL_OFS) && wdata[CTRL_ACK];
    v_c_end = (r.vst == V_RESTART) && r.tick && (r.vsec == RETARD_S + rs - SEC_ONE);
    second = $countones(r.alarmed) > 1;
    pas_kind = (r.day_mode != DAY_PS);
    found = 1'b0;
    qual = 1'b0;
    lat = 1'b0;
    av_set = 1'b0;
    n = r;
    n.tick = 1'b0;
    n.loop_reset = 1'b0;
    n.rdata = '0;

    // seconds divider feeding every timer
    if (r.div == CNT_W'(TICK_CYCLES - 1))
    begin
      n.div = '0;
      n.tick = 1'b1;
    end
    else
    begin
      n.div = r.div + CNT_W'(1);
    end

    // pins pass two flops before use
    n.sync1 = point_in;
    n.sync2 = r.sync1;

    // register writes; times are kept inside their legal windows
    if (wr_stb)
    begin
      unique case (addr)
        CTRL_OFS:
        begin
          n.day_mode = wdata[CTRL_DAY_LSB +: 2];
          n.pas_en = wdata[CTRL_PAS_EN];
          n.sup_latch = wdata[CTRL_SUP_LATCH];
        end
        VERIF_T_OFS: n.verif_t = clamp(wdata[SEC_W-1:0], VERIF_MIN_S, VERIF_MAX_S);
        WF_T_OFS: n.wf_t = clamp(wdata[SEC_W-1:0], WF_MIN_S, WF_MAX_S);
        PS_T_OFS: n.ps_t = clamp(wdata[SEC_W-1:0], DLY_MIN_S, DLY_MAX_S);
        PAS_T_OFS: n.pas_t = clamp(wdata[SEC_W-1:0], DLY_MIN_S, DLY_MAX_S);
        default:
        begin
          // config words; other addresses drop the write
          if ((addr >= PCFG_BASE) && (idx < ADDR_W'(NUM_POINTS)) && (addr[1:0] == 2'h0))
          begin
            n.cfg[idx[PT_W-1:0]] = wdata[CFG_W-1:0];
          end
        end
      endcase
    end

    // per point qualification, latching and alarm registration
    for (int i = 0; i < NUM_POINTS; i++)
    begin
      typ = point_type_e'(r.cfg[i][CFG_TYPE_LSB +: CFG_TYPE_W]);
      eff = fire_like(typ) ? eff_of(r.cfg[i], r.day_mode, r.pas_en) : EFF_NONE;
      // waterflow timer: each delayed point counts on its own
      if ((typ == PT_WF_DELAY) && r.cfg[i][CFG_WF_EN])
      begin
        if (!r.sync2[i] || pan_rst)
          n.wf_cnt[i] = '0;
        else if (r.tick && (r.wf_cnt[i] < r.wf_t))
          n.wf_cnt[i] = r.wf_cnt[i] + SEC_ONE;
        qual = r.sync2[i] && (r.wf_cnt[i] >= r.wf_t);
      end
      else
      begin
        n.wf_cnt[i] = '0;
        qual = r.sync2[i];
      end
      // verification points raise an alarm only from the sequencer
      av_set = r.sync2[i] && ((r.vst == V_CONFIRM) ||
        (v_c_end && (PT_W'(i) == r.vpt)));
      // fixed latching by type; supervisory follows the panel setting
      lat = fire_like(typ) || (typ == PT_GAS) ||
        ((typ == PT_SUPERVISORY) && r.sup_latch);
      if (eff == EFF_AV)
        qual = av_set || (r.alarmed[i] && qual);
      // the set wins over a panel reset arriving in the same cycle
      n.latched[i] = lat ? ((r.latched[i] && !pan_rst) || qual) : qual;
      n.alarmed[i] = (r.alarmed[i] && !pan_rst) || (fire_like(typ) && qual);
      // judged on the new alarm, so a held output never blinks on first
      held[i] = n.alarmed[i] && ((eff == EFF_PAS) || (eff == EFF_PS));
    end

    // verification sequencer, one for the whole panel
    if (r.tick && (r.vst != V_IDLE))
      n.vsec = r.vsec + SEC_ONE;
    unique case (r.vst)
      V_IDLE:
      begin
        n.vsec = '0;
        for (int i = 0; i < NUM_POINTS; i++)
        begin
          if (!found && r.sync2[i] && !r.alarmed[i] &&
            (point_type_e'(r.cfg[i][CFG_TYPE_LSB +: CFG_TYPE_W]) == PT_FIRE_AUTO) &&
            (eff_of(r.cfg[i], r.day_mode, r.pas_en) == EFF_AV))
          begin
            found = 1'b1;
            n.vpt = PT_W'(i);
            n.vst = V_RETARD;
            n.loop_reset = 1'b1;
            n.loop_reset_pt = PT_W'(i);
          end
        end
      end
      V_RETARD:
      begin
        if (r.tick && (r.vsec == RETARD_S - SEC_ONE))
          n.vst = V_RESTART;
      end
      V_RESTART:
      begin
        // retard plus restart never exceeds the 30 s ceiling
        if (v_c_end)
          n.vst = r.sync2[r.vpt] ? V_IDLE : V_CONFIRM;
      end
      V_CONFIRM:
      begin
        if (r.sync2[r.vpt] || (r.tick && (r.vsec >= r.verif_t - SEC_ONE)))
          n.vst = V_IDLE;
      end
    endcase
    if (pan_rst)
    begin
      n.vst = V_IDLE;
      n.vsec = '0;
    end

    // shared pre-signal / sequence timer; the day mode picks which one runs
    if (r.tick && ((r.dst == D_ACK) || (r.dst == D_WAIT)))
      n.dsec = r.dsec + SEC_ONE;
    unique case (r.dst)
      D_IDLE:
      begin
        n.dsec = '0;
        if (|held)
          n.dst = pas_kind ? D_ACK : D_WAIT;
      end
      D_ACK:
      begin
        if (ack_wr)
        begin
          n.dst = D_WAIT;
          n.dsec = '0;
        end
        else if (r.tick && (r.dsec == ACK_S - SEC_ONE))
          n.dst = D_RELEASED;
      end
      D_WAIT:
      begin
        if (r.tick && (r.dsec >= lim - SEC_ONE))
          n.dst = D_RELEASED;
      end
      D_RELEASED: n.dst = D_RELEASED;
    endcase
    if ((r.dst != D_IDLE) && second)
      n.dst = D_RELEASED;
    if (pan_rst)
    begin
      n.dst = D_IDLE;
      n.dsec = '0;
    end

    // outputs: indication at once, mapped outputs may wait
    for (int i = 0; i < NUM_POINTS; i++)
      n.out_act[i] = n.alarmed[i] && (!held[i] || (n.dst == D_RELEASED));
    n.alarm = |n.alarmed;
    n.verif_zone = (n.vst != V_IDLE);
    n.presig_zone = (n.dst != D_IDLE) && (r.day_mode == DAY_PS);
    n.evac = (n.dst == D_RELEASED) && pas_kind;

    // register reads, answered in the next cycle; unmapped reads zero
    if (rd_stb)
    begin
      unique case (addr)
        CTRL_OFS: n.rdata = {28'h0000000, r.sup_latch, r.pas_en, r.day_mode};
        VERIF_T_OFS: n.rdata = {24'h000000, r.verif_t};
        WF_T_OFS: n.rdata = {24'h000000, r.wf_t};
        PS_T_OFS: n.rdata = {24'h000000, r.ps_t};
        PAS_T_OFS: n.rdata = {24'h000000, r.pas_t};
        STATUS_OFS: n.rdata = {24'h000000, r.evac, r.presig_zone, r.verif_zone, r.alarm,
          r.dst, r.vst};
        ACTIVE_OFS: n.rdata = 32'(r.latched);
        ALARMED_OFS: n.rdata = 32'(r.alarmed);
        default:
        begin
          if ((addr >= PCFG_BASE) && (idx < ADDR_W'(NUM_POINTS)) && (addr[1:0] == 2'h0))
            n.rdata = 32'(r.cfg[idx[PT_W-1:0]]);
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.verif_t <= VERIF_DEF_S;
      r.wf_t <= WF_DEF_S;
      r.ps_t <= DLY_DEF_S;
      r.pas_t <= DLY_DEF_S;
    end
    else
    begin
      r <= n;
    end
  end

  // outputs straight from the state flops
  assign rdata = r.rdata;
  assign alarm_out = r.alarm;
  assign out_act = r.out_act;
  assign verif_zone = r.verif_zone;
  assign presig_zone = r.presig_zone;
  assign evac_out = r.evac;
  assign loop_reset = r.loop_reset;
  assign loop_reset_pt = r.loop_reset_pt;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  retard_len_a: assert property (
    (r.vst == V_RESTART) |-> (r.vsec >= RETARD_S))
    else $error("restart entered before 20 s retard");
  span_max_a: assert property (
    ((r.vst == V_RETARD) || (r.vst == V_RESTART)) |-> (r.vsec <= SPAN_MAX_S) && !r.alarmed[r.vpt])
    else $error("verification span too long or alarmed early");
  verif_period_a: assert property (
    (r.vst == V_CONFIRM) |-> (r.vsec <= r.verif_t))
    else $error("confirmation outlived verification period");
  loop_reset_a: assert property (
    ($past(r.vst) == V_IDLE) && (r.vst == V_RETARD) |->
    r.loop_reset && (r.loop_reset_pt == r.vpt))
    else $error("no loop reset on verification start");
  verif_zone_a: assert property (
    r.verif_zone && (r.vsec < RETARD_S + RESTART_DET_S - SEC_ONE) &&
    !(wr_stb && (addr == CTRL_OFS) && wdata[CTRL_RESET]) |=> r.verif_zone)
    else $error("verification zone flag dropped early");
  wf_restart_a: assert property (
    !r.sync2[0] |=> (r.wf_cnt[0] == '0))
    else $error("waterflow timer not cleared on drop");
  latch_hold_a: assert property (
    r.alarmed[0] && !(wr_stb && (addr == CTRL_OFS) && wdata[CTRL_RESET]) |=> r.alarmed[0])
    else $error("fire alarm released without reset");
  mode_excl_a: assert property (
    !(r.presig_zone && r.evac))
    else $error("pre-signal and sequence both active");
  ack_timeout_a: assert property (
    (r.dst == D_ACK) && r.tick && (r.dsec == ACK_S - SEC_ONE) && !wr_stb |=>
    (r.dst == D_RELEASED))
    else $error("sequence not released after 15 s");

endmodule : alarm_delay_core

`default_nettype wire

/* tb/loop_point_model.sv */
/*
  loop point model: one smoke state per point, muted after a loop reset.
  assumes loop resets arrive as one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module loop_point_model #(
  parameter int N = 4,
  parameter int QUIET = 100 // power-up silence in cycles
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] smoke,
  input wire logic loop_reset,
  input wire logic [$clog2(N)-1:0] loop_reset_pt,
  output logic [N-1:0] point_in
);
  // cycles of restart left per point
  int quiet [N];
  // a reset detector reads idle while it powers up again
  always_ff @(posedge clk or posedge rst)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (rst)
        quiet[i] <= 0;
      else if (loop_reset && int'(loop_reset_pt) == i)
        quiet[i] <= QUIET;
      else if (quiet[i] > 0)
        quiet[i] <= quiet[i] - 1;
    end
  end
  // smoke still present reappears once restart is over
  always_comb
    for (int i = 0; i < N; i++)
      point_in[i] = smoke[i] && quiet[i] == 0;
endmodule : loop_point_model
`default_nettype wire

/* tb/tb_fire_alarm_delay_processing.sv */
/*
  self-checking bench for the alarm delay core with a loop point model.
  assumes a 10-cycle tick so that one second lasts 200 ns.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_fire_alarm_delay_processing;
  import fad_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [3:0] smoke = 4'h0; // smoke seen by the loop model
  logic [3:0] point_in, out_act;
  logic [31:0] rdata, d;
  logic alarm_out, verif_zone, presig_zone, evac_out, loop_reset;
  logic [1:0] loop_reset_pt;
  int n_fail = 0;
  int n_compared = 0;
  always #10 clk = ~clk;
  alarm_delay_core #(.NUM_POINTS(4), .TICK_CYCLES(10)) alarm_delay_core_inst (.clk(clk),
    .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .point_in(point_in), .rdata(rdata), .alarm_out(alarm_out), .out_act(out_act),
    .verif_zone(verif_zone), .presig_zone(presig_zone), .evac_out(evac_out),
    .loop_reset(loop_reset), .loop_reset_pt(loop_reset_pt));
  loop_point_model #(.N(4), .QUIET(100)) loop_point_model_inst (.clk(clk), .rst(rst),
    .smoke(smoke), .loop_reset(loop_reset), .loop_reset_pt(loop_reset_pt),
    .point_in(point_in));
  // ---------------------------------------------------------------
  // bus and timing helpers
  // ---------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  // read data only stand in the cycle after the strobe
  task rd(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // bounded wait, never a bare hang
  task wait_alarm(input int n);
    for (int i = 0; i < n && alarm_out !== 1'b1; i++)
      cyc(1);
  endtask : wait_alarm
  // let the synchronised inputs fall first, else a still active point re-sets
  task panel_reset;
    smoke <= 4'h0;
    cyc(4);
    wr(CTRL_OFS, 32'h20);
    cyc(4);
  endtask : panel_reset
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_defaults;
    rd(VERIF_T_OFS);
    `CHK("verif_t", {24'h0, VERIF_DEF_S}, d)
    rd(WF_T_OFS);
    `CHK("wf_t", {24'h0, WF_DEF_S}, d)
    rd(PS_T_OFS);
    `CHK("ps_t", {24'h0, DLY_DEF_S}, d)
    rd(PAS_T_OFS);
    `CHK("pas_t", {24'h0, DLY_DEF_S}, d)
    rd(12'h020);
    `CHK("unmapped", 32'h0, d)
    $display("test defaults done");
  endtask : t_defaults
  // manual point stays alarmed after its input drops
  task t_latch;
    wr(PCFG_BASE + 12'h004, 32'h01);
    smoke[1] <= 1'b1;
    cyc(6);
    `CHK("out_act1", 1'b1, out_act[1])
    smoke[1] <= 1'b0;
    cyc(8);
    `CHK("latched", 1'b1, alarm_out)
    panel_reset();
    `CHK("cleared", 1'b0, alarm_out)
    // supervisory point follows its input unless the panel latches it
    wr(PCFG_BASE + 12'h00C, 32'h05);
    smoke[3] <= 1'b1;
    cyc(6);
    smoke[3] <= 1'b0;
    cyc(6);
    rd(ACTIVE_OFS);
    `CHK("sup_free", 32'h0, d)
    wr(CTRL_OFS, 32'h08);
    smoke[3] <= 1'b1;
    cyc(6);
    smoke[3] <= 1'b0;
    cyc(6);
    rd(ACTIVE_OFS);
    `CHK("sup_held", 32'h8, d)
    `CHK("sup_no_fire", 1'b0, alarm_out)
    panel_reset();
    $display("test latch done");
  endtask : t_latch
  task t_verif;
    wr(PCFG_BASE, 32'h10);
    smoke[0] <= 1'b1;
    for (int i = 0; i < 10 && loop_reset !== 1'b1; i++)
      cyc(1);
    `CHK("loop_reset_pt", 2'h0, loop_reset_pt)
    cyc(2);
    `CHK("verif_zone", 1'b1, verif_zone)
    cyc(180);
    `CHK("retard", 1'b0, alarm_out)
    wait_alarm(110);
    `CHK("confirmed", 1'b1, alarm_out)
    panel_reset();
    smoke[0] <= 1'b1;
    cyc(20);
    smoke[0] <= 1'b0;
    cyc(520);
    `CHK("zone_held", 1'b1, verif_zone)
    cyc(110);
    `CHK("zone_off", 2'b00, {verif_zone, alarm_out})
    // re-alarm inside the confirmation phase alarms at once
    smoke[0] <= 1'b1;
    cyc(20);
    smoke[0] <= 1'b0;
    cyc(300);
    smoke[0] <= 1'b1;
    wait_alarm(10);
    `CHK("realarm", 1'b1, alarm_out)
    panel_reset();
    $display("test verification done");
  endtask : t_verif
  // a break restarts the point's own timer
  task t_wf;
    wr(WF_T_OFS, 32'h05);
    rd(WF_T_OFS);
    `CHK("wf_clamp", {24'h0, WF_MIN_S}, d)
    wr(PCFG_BASE, 32'h43);
    smoke[0] <= 1'b1;
    cyc(60);
    smoke[0] <= 1'b0;
    cyc(3);
    smoke[0] <= 1'b1;
    cyc(80);
    `CHK("wf_early", 1'b0, alarm_out)
    wait_alarm(40);
    `CHK("wf_alarm", 1'b1, alarm_out)
    panel_reset();
    $display("test waterflow done");
  endtask : t_wf
  task t_presig;
    wr(CTRL_OFS, 32'h02);
    wr(PCFG_BASE, 32'h20);
    smoke[0] <= 1'b1;
    cyc(8);
    `CHK("ps_ind", 3'b101, {alarm_out, out_act[0], presig_zone})
    smoke[1] <= 1'b1;
    cyc(8);
    `CHK("ps_both", 2'b11, out_act[1:0])
    panel_reset();
    `CHK("ps_zone_off", 1'b0, presig_zone)
    wr(CTRL_OFS, 32'h05);
    smoke[0] <= 1'b1;
    cyc(130);
    `CHK("pas_hold", 1'b0, evac_out)
    cyc(45);
    `CHK("pas_evac", 1'b1, evac_out)
    panel_reset();
    // acknowledged alarm runs the 60 s investigation time, then releases
    wr(CTRL_OFS, 32'h05);
    wr(PAS_T_OFS, 32'h3C);
    smoke[0] <= 1'b1;
    cyc(40);
    wr(CTRL_OFS, 32'h15);
    cyc(560);
    `CHK("pas_invest", 1'b0, evac_out)
    cyc(60);
    `CHK("pas_release", 1'b1, evac_out)
    panel_reset();
    $display("test day delays done");
  endtask : t_presig
  task final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    final_report();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    t_defaults();
    t_latch();
    t_verif();
    t_wf();
    t_presig();
    final_report();
  end
endmodule : tb_fire_alarm_delay_processing
`default_nettype wire
